// [rtl/pms_top.sv]
// Processor mode select: mode state, access routing and pin ownership.
// Assumes CPU requests last one cycle and memories answer one cycle after a strobe.
//
// Behaviour
// [RULE1] Exactly three modes: single-chip, memory expansion, microprocessor; they steer pins and map.
// [RULE2] Single-chip mode: all port pins are general or peripheral I/O, no bus signals.
// [RULE3] Single-chip mode: only special function area, internal RAM and internal ROM reachable.
// [RULE4] Single-chip mode: software may stop the enable strobe output.
// [RULE5] External modes: external devices may sit anywhere in the 16-Mbyte space.
// [RULE6] Microprocessor mode: internal ROM disabled, its range becomes external area.
// [RULE7] Microprocessor mode: clock output pin carries the phase-one clock.
// [RULE8] External modes: ports 0-3 and two port-4 bits carry bus signals only.
// [RULE9] Overlapped internal reads return internal data; external read data is ignored.
// [RULE10] Overlapped internal writes update internal location and drive the bus together.
// [RULE11] Writes to reserved SPECIAL_FUNCTION_AREA addresses are ignored.
// [RULE12] External modes: software may stop the phase-one clock output.
// [RULE13] Mode field: 00 single, 01 expansion, 10 microprocessor; 11 never selected.
// [RULE14] A written mode takes effect at the next enable strobe rising edge.
// [RULE15] Mode pin low: leave reset in single-chip mode; software may change modes.
// [RULE16] Mode pin high: leave reset in microprocessor mode; software keeps it there.
// [RULE17] Pins given to the bus leave port control in the cycle the mode changes.
`timescale 1ns/10ps
module pms_top #(
    parameter logic [23:0] IRAM_BASE = pms_pkg::PMS_IRAM_BASE,
    parameter logic [23:0] IRAM_LAST = pms_pkg::PMS_IRAM_LAST,
    parameter logic [23:0] IROM_BASE = pms_pkg::PMS_IROM_BASE,
    parameter logic [23:0] IROM_LAST = pms_pkg::PMS_IROM_LAST
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Strap and software controls
    input wire logic mode_select_pin,
    input wire logic mode_wr,
    input wire logic [1:0] mode_wdata,
    input wire logic e_stop,
    input wire logic phi1_en,
    // Enable strobe and phase-one clock from the bus interface unit
    input wire logic e_strobe,
    input wire logic phi1,
    // CPU side
    input wire pms_pkg::pms_req_s cpu_req,
    output logic cpu_rvalid,
    output logic [pms_pkg::PMS_DATA_W-1:0] cpu_rdata,
    // Internal memories and special function area
    output pms_pkg::pms_req_s int_req,
    input wire logic [pms_pkg::PMS_DATA_W-1:0] int_rdata,
    // Bus interface unit
    output pms_pkg::pms_req_s ext_req,
    input wire logic [pms_pkg::PMS_DATA_W-1:0] ext_rdata,
    input wire logic [pms_pkg::PMS_BUS_PIN_W-1:0] bus_out,
    input wire logic [pms_pkg::PMS_BUS_PIN_W-1:0] bus_oe,
    output logic [pms_pkg::PMS_BUS_PIN_W-1:0] bus_in,
    // Port registers
    input wire logic [pms_pkg::PMS_PIN_W-1:0] port_out,
    input wire logic [pms_pkg::PMS_PIN_W-1:0] port_dir,
    output logic [pms_pkg::PMS_PIN_W-1:0] port_in,
    // Pads
    input wire logic [pms_pkg::PMS_PIN_W-1:0] pin_in,
    output logic [pms_pkg::PMS_PIN_W-1:0] pin_out,
    output logic [pms_pkg::PMS_PIN_W-1:0] pin_oe,
    output logic e_pin_out,
    output logic e_pin_oe,
    // Status
    output pms_pkg::pms_mode_e mode
);
    import pms_pkg::*;

    // ================================================================
    // State
    typedef struct packed {
        pms_mode_e mode;
        logic strapped;
        logic locked;
        logic pend;
        logic [1:0] pend_field;
        logic e_prev;
        pms_req_s int_req;
        pms_req_s ext_req;
        logic rd1;
        logic rd1_int;
        logic rd2;
        logic rd2_int;
        logic rvalid;
        logic [PMS_DATA_W-1:0] rdata;
        logic [PMS_PIN_W-1:0] pin_sample;
    } pms_state_s;

    pms_state_s state;
    pms_state_s next_state;
    pms_area_s area;
    logic e_rise;
    logic field_ok;

    pms_addr_decode #(
        .IRAM_BASE(IRAM_BASE),
        .IRAM_LAST(IRAM_LAST),
        .IROM_BASE(IROM_BASE),
        .IROM_LAST(IROM_LAST)
    ) u_decode (
        .addr(cpu_req.addr),
        .mode(state.mode),
        .area(area)
    );

    pms_pin_mux u_pin_mux (
        .mode(state.mode),
        .phi1(phi1),
        .phi1_en(phi1_en),
        .port_out(port_out),
        .port_dir(port_dir),
        .bus_out(bus_out),
        .bus_oe(bus_oe),
        .pin_out(pin_out),
        .pin_oe(pin_oe)
    );

    assign e_rise = e_strobe && !state.e_prev;

    // ================================================================
    // Mode field acceptance
    always_comb begin
        unique case (mode_wdata)
            PMS_FIELD_SINGLE: field_ok = !state.locked; // RULE16
            PMS_FIELD_EXPAND: field_ok = !state.locked; // RULE16
            PMS_FIELD_MICRO: field_ok = 1'b1;
            PMS_FIELD_ILLEGAL: field_ok = 1'b0; // RULE13
        endcase
    end

    // ================================================================
    // Next state
    always_comb begin
        next_state = state;
        next_state.e_prev = e_strobe;
        next_state.pin_sample = pin_in;
        // Strap is caught at the first edge after release, never under reset
        if (!state.strapped) begin
            next_state.strapped = 1'b1;
            next_state.locked = mode_select_pin;
            next_state.mode = mode_select_pin ? PMS_MICRO : PMS_SINGLE; // RULE15 RULE16
        end
        // Apart from the strap capture, mode moves only on the enable strobe edge
        if (state.pend && e_rise) begin
            next_state.pend = 1'b0;
            unique case (state.pend_field)
                PMS_FIELD_EXPAND: next_state.mode = PMS_EXPAND; // RULE14 RULE13
                PMS_FIELD_MICRO: next_state.mode = PMS_MICRO; // RULE14 RULE13
                default: next_state.mode = PMS_SINGLE; // RULE14 RULE13
            endcase
        end
        // A write in the same cycle as the edge waits for the next edge
        if (mode_wr && field_ok && state.strapped) begin
            next_state.pend = 1'b1;
            next_state.pend_field = mode_wdata;
        end
        // Access routing
        next_state.int_req = cpu_req;
        next_state.ext_req = cpu_req;
        next_state.int_req.valid = cpu_req.valid && area.internal && state.strapped
            && !(cpu_req.write && area.reserved); // RULE11 RULE3
        // Single-chip mode never starts a bus cycle; external modes reach the whole space
        next_state.ext_req.valid = cpu_req.valid && state.strapped
            && (state.mode != PMS_SINGLE); // RULE3 RULE5 RULE10
        next_state.rd1 = cpu_req.valid && !cpu_req.write && state.strapped
            && (area.internal || state.mode != PMS_SINGLE);
        next_state.rd1_int = area.internal; // RULE9
        next_state.rd2 = state.rd1;
        next_state.rd2_int = state.rd1_int;
        next_state.rvalid = state.rd2;
        if (state.rd2) begin
            next_state.rdata = state.rd2_int ? int_rdata : ext_rdata; // RULE9
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= '0;
            state.mode <= PMS_SINGLE;
        end else begin
            state <= next_state;
        end
    end

    // ================================================================
    // Outputs
    assign mode = state.mode; // RULE1
    assign int_req = state.int_req;
    assign ext_req = state.ext_req;
    assign cpu_rvalid = state.rvalid;
    assign cpu_rdata = state.rdata;
    assign port_in = state.pin_sample;
    assign bus_in = state.pin_sample[PMS_BUS_PIN_W-1:0];
    assign e_pin_out = e_strobe;
    // Stopping the strobe is only honoured where no external device needs it
    assign e_pin_oe = !((state.mode == PMS_SINGLE) && e_stop); // RULE4

    // ================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence int_read_s;
        cpu_req.valid && !cpu_req.write && area.internal && state.strapped;
    endsequence

    sequence ovl_write_s;
        cpu_req.valid && cpu_req.write && area.internal && !area.reserved
            && state.strapped && (state.mode != PMS_SINGLE);
    endsequence

    sequence mode_request_s;
        mode_wr && state.strapped && field_ok && !state.pend;
    endsequence

    sequence mode_apply_s;
        state.pend && e_rise;
    endsequence

    mode_on_edge_a: assert property ( // RULE14
        state.strapped && (next_state.mode != state.mode) |-> state.pend && e_rise)
        else $error("mode changed without a pending write and strobe edge");

    mode_pending_a: assert property ( // RULE14
        mode_request_s ##1 !e_rise[*2] |-> state.pend)
        else $error("pending mode lost before strobe edge");

    illegal_code_a: assert property ( // RULE13
        mode_wr && mode_wdata == PMS_FIELD_ILLEGAL && !state.pend |=> !state.pend)
        else $error("mode code 11 accepted");

    strap_lock_a: assert property ( // RULE16
        state.locked |-> state.mode == PMS_MICRO)
        else $error("locked device left microprocessor mode");

    strap_single_a: assert property ( // RULE15
        !state.strapped && !mode_select_pin |=> state.mode == PMS_SINGLE && !state.locked)
        else $error("low strap did not give single-chip mode");

    single_no_bus_a: assert property ( // RULE3
        ext_req.valid |-> $past(state.mode) != PMS_SINGLE)
        else $error("bus cycle issued in single-chip mode");

    rom_external_a: assert property ( // RULE6
        cpu_req.valid && state.strapped && state.mode == PMS_MICRO
            && cpu_req.addr >= IROM_BASE && cpu_req.addr <= IROM_LAST
            && !(cpu_req.addr <= IRAM_LAST)
        |=> ext_req.valid && !int_req.valid)
        else $error("internal ROM reached in microprocessor mode");

    overlap_read_a: assert property ( // RULE9
        int_read_s |-> ##3 (cpu_rvalid && cpu_rdata == $past(int_rdata)))
        else $error("internal read did not return internal data");

    overlap_write_a: assert property ( // RULE10
        ovl_write_s |=> int_req.valid && ext_req.valid && int_req.wdata == ext_req.wdata)
        else $error("overlapped write not sent to both areas together");

    reserved_write_a: assert property ( // RULE11
        cpu_req.valid && cpu_req.write && area.reserved |=> !int_req.valid)
        else $error("reserved address written");

    bus_pins_a: assert property ( // RULE8
        state.mode != PMS_SINGLE |->
            pin_oe[PMS_BUS_PIN_W-1:0] == bus_oe && pin_out[PMS_BUS_PIN_W-1:0] == bus_out)
        else $error("bus pins not owned by the bus in external mode");

    pin_handover_a: assert property ( // RULE17
        $changed(state.mode) && state.mode != PMS_SINGLE |->
            pin_oe[PMS_BUS_PIN_W-1:0] == bus_oe)
        else $error("pins not handed to the bus with the mode change");

    single_pins_a: assert property ( // RULE2
        state.mode == PMS_SINGLE |-> pin_oe == port_dir && pin_out == port_out)
        else $error("port pins not under port control in single-chip mode");

    clock_pin_a: assert property ( // RULE7
        state.mode == PMS_MICRO |->
            pin_oe[PMS_CLK_PIN] && pin_out[PMS_CLK_PIN] == (phi1 & phi1_en))
        else $error("clock output pin wrong in microprocessor mode");

    clock_stop_a: assert property ( // RULE12
        state.mode == PMS_EXPAND && !phi1_en |-> pin_out[PMS_CLK_PIN] == port_out[PMS_CLK_PIN])
        else $error("phase-one clock not stopped in expansion mode");

    e_stop_a: assert property ( // RULE4
        (state.mode == PMS_SINGLE && e_stop) |-> !e_pin_oe)
        else $error("enable strobe not stopped in single-chip mode");

    ext_strobe_a: assert property ( // RULE4
        state.mode != PMS_SINGLE |-> e_pin_oe && e_pin_out == e_strobe)
        else $error("enable strobe missing in external mode");

    // Field codes and mode encoding share values, so the applied field is the mode
    mode_apply_a: assert property ( // RULE14 RULE13
        mode_apply_s |=> 2'(state.mode) == $past(state.pend_field))
        else $error("applied mode differs from the pending field");

    mode_legal_a: assert property ( // RULE1
        state.mode inside {PMS_SINGLE, PMS_EXPAND, PMS_MICRO})
        else $error("mode outside the three processor modes");

    single_refuse_a: assert property ( // RULE3
        cpu_req.valid && state.strapped && state.mode == PMS_SINGLE && !area.internal
        |=> !int_req.valid && !ext_req.valid)
        else $error("outside access started in single-chip mode");

    ext_read_a: assert property ( // RULE5
        cpu_req.valid && !cpu_req.write && state.strapped && state.mode != PMS_SINGLE
            && !area.internal
        |-> ##3 (cpu_rvalid && cpu_rdata == $past(ext_rdata)))
        else $error("external read did not return external data");

endmodule

// [pkg/pms_pkg.sv]
// Shared types and constants for the processor mode select block.
// Assumes a 24-bit CPU address, 16-bit data and five 8-bit mode-dependent ports.
package pms_pkg;

    // ================================================================
    // Widths
    localparam int PMS_ADDR_W = 24;
    localparam int PMS_DATA_W = 16;
    localparam int PMS_PIN_W = 40;
    localparam int PMS_BUS_PIN_W = 34;
    localparam int PMS_CLK_PIN = 34;

    // ================================================================
    // Mode field codes
    localparam logic [1:0] PMS_FIELD_SINGLE = 2'h0;
    localparam logic [1:0] PMS_FIELD_EXPAND = 2'h1;
    localparam logic [1:0] PMS_FIELD_MICRO = 2'h2;
    localparam logic [1:0] PMS_FIELD_ILLEGAL = 2'h3;

    // ================================================================
    // Address map of the internal area
    localparam logic [23:0] PMS_SPECIAL_BASE = 24'h000000;
    localparam logic [23:0] PMS_SPECIAL_LAST = 24'h00007f;
    localparam logic [23:0] PMS_RSV_A = 24'h00001c;
    localparam logic [23:0] PMS_RSV_B = 24'h00001d;
    localparam logic [23:0] PMS_RSV_C = 24'h000062;
    localparam logic [23:0] PMS_IRAM_BASE = 24'h000080;
    localparam logic [23:0] PMS_IRAM_LAST = 24'h00087f;
    localparam logic [23:0] PMS_IROM_BASE = 24'h008000;
    localparam logic [23:0] PMS_IROM_LAST = 24'h00ffff;

    // ================================================================
    // Types
    typedef enum logic [1:0] {
        PMS_SINGLE,
        PMS_EXPAND,
        PMS_MICRO
    } pms_mode_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [PMS_ADDR_W-1:0] addr;
        logic [PMS_DATA_W-1:0] wdata;
    } pms_req_s;

    typedef struct packed {
        logic special;
        logic iram;
        logic irom;
        logic internal;
        logic reserved;
    } pms_area_s;

endpackage

// [rtl/pms_addr_decode.sv]
// Address decoder: classifies a CPU address against the internal area.
// Assumes the mode input is the currently active processor mode.
`timescale 1ns/10ps
module pms_addr_decode #(
    parameter logic [23:0] IRAM_BASE = pms_pkg::PMS_IRAM_BASE,
    parameter logic [23:0] IRAM_LAST = pms_pkg::PMS_IRAM_LAST,
    parameter logic [23:0] IROM_BASE = pms_pkg::PMS_IROM_BASE,
    parameter logic [23:0] IROM_LAST = pms_pkg::PMS_IROM_LAST
) (
    // Address and mode
    input wire logic [pms_pkg::PMS_ADDR_W-1:0] addr,
    input wire pms_pkg::pms_mode_e mode,
    // Classification
    output pms_pkg::pms_area_s area
);
    import pms_pkg::*;

    always_comb begin
        area.special = (addr >= PMS_SPECIAL_BASE) && (addr <= PMS_SPECIAL_LAST);
        area.iram = (addr >= IRAM_BASE) && (addr <= IRAM_LAST);
        // Internal ROM vanishes in microprocessor mode
        area.irom = (addr >= IROM_BASE) && (addr <= IROM_LAST) && (mode != PMS_MICRO); // RULE6
        area.internal = area.special || area.iram || area.irom;
        area.reserved = (addr == PMS_RSV_A) || (addr == PMS_RSV_B) || (addr == PMS_RSV_C);
    end

endmodule

// [rtl/pms_pin_mux.sv]
// Pin multiplexer for ports 0 to 4 according to the active processor mode.
// Assumes port registers and bus signals come from neighbouring blocks.
`timescale 1ns/10ps
module pms_pin_mux (
    // Mode and clock output control
    input wire pms_pkg::pms_mode_e mode,
    input wire logic phi1,
    input wire logic phi1_en,
    // Port register side
    input wire logic [pms_pkg::PMS_PIN_W-1:0] port_out,
    input wire logic [pms_pkg::PMS_PIN_W-1:0] port_dir,
    // Bus interface unit side
    input wire logic [pms_pkg::PMS_BUS_PIN_W-1:0] bus_out,
    input wire logic [pms_pkg::PMS_BUS_PIN_W-1:0] bus_oe,
    // Pads
    output logic [pms_pkg::PMS_PIN_W-1:0] pin_out,
    output logic [pms_pkg::PMS_PIN_W-1:0] pin_oe
);
    import pms_pkg::*;

    logic ext_mode;

    assign ext_mode = (mode != PMS_SINGLE);

    // ================================================================
    // Per-pin selection
    for (genvar i = 0; i < PMS_PIN_W; i++) begin : g_pin
        if (i < PMS_BUS_PIN_W) begin : g_bus
            // Port registers lose these pins as soon as the mode changes
            assign pin_out[i] = ext_mode ? bus_out[i] : port_out[i]; // RULE8 RULE17 RULE2
            assign pin_oe[i] = ext_mode ? bus_oe[i] : port_dir[i]; // RULE8 RULE17 RULE2
        end else if (i == PMS_CLK_PIN) begin : g_clk
            always_comb begin
                unique case (mode)
                    PMS_MICRO: begin
                        // Stopped clock still owns the pin, held low
                        pin_out[i] = phi1 & phi1_en; // RULE7 RULE12
                        pin_oe[i] = 1'b1; // RULE7
                    end
                    PMS_EXPAND: begin
                        pin_out[i] = phi1_en ? phi1 : port_out[i]; // RULE12
                        pin_oe[i] = phi1_en | port_dir[i];
                    end
                    PMS_SINGLE: begin
                        pin_out[i] = port_out[i]; // RULE2
                        pin_oe[i] = port_dir[i];
                    end
                    default: begin
                        pin_out[i] = port_out[i];
                        pin_oe[i] = port_dir[i];
                    end
                endcase
            end
        end else begin : g_port
            assign pin_out[i] = port_out[i];
            assign pin_oe[i] = port_dir[i];
        end
    end

endmodule

// [sim/pms_ext_model.sv]
// Behavioural external memory standing on the expansion bus.
// Assumes one request per clock and read data wanted one cycle after it.
`timescale 1ns/10ps
module pms_ext_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Bus interface unit side
    input wire pms_pkg::pms_req_s ext_req,
    output logic [pms_pkg::PMS_DATA_W-1:0] ext_rdata
);
    import pms_pkg::*;

    logic [PMS_DATA_W-1:0] mem [logic [PMS_ADDR_W-1:0]];

    // ================================================================
    // Answer
    // Outside a read answer the bus is released: show the inverse of the last
    // word, so a design that samples a cycle late never sees matching data.
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_rdata <= 16'h0000;
        end else if (ext_req.valid && ext_req.write) begin
            mem[ext_req.addr] = ext_req.wdata;
            ext_rdata <= ~ext_rdata;
        end else if (ext_req.valid) begin
            if (mem.exists(ext_req.addr)) begin
                ext_rdata <= mem[ext_req.addr];
            end else begin
                ext_rdata <= ext_req.addr[15:0] ^ 16'h3c3c;
            end
        end else begin
            ext_rdata <= ~ext_rdata;
        end
    end
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the processor mode select block.
// Assumes the internal memories answer one cycle after their strobe.
`timescale 1ns/10ps
module tb_top;
    import pms_pkg::*;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic mode_select_pin = 1'b0;
    logic mode_wr = 1'b0;
    logic [1:0] mode_wdata = 2'h0;
    logic e_stop = 1'b0;
    logic phi1_en = 1'b0;
    logic e_strobe = 1'b0;
    logic phi1 = 1'b0;
    pms_req_s cpu_req = '0;
    logic [15:0] int_rdata = 16'h0000;
    logic [33:0] bus_out = '0;
    logic [33:0] bus_oe = '0;
    logic [39:0] port_out = '0;
    logic [39:0] port_dir = '0;
    logic [39:0] pin_in = '0;
    logic cpu_rvalid, e_pin_out, e_pin_oe;
    logic [15:0] cpu_rdata, ext_rdata, int_wd, ext_wd;
    pms_req_s int_req, ext_req;
    logic [33:0] bus_in;
    logic [39:0] port_in, pin_out, pin_oe;
    pms_mode_e mode;
    logic [15:0] exp_q[$];
    int err_count = 0;
    int total_checks = 0;
    int int_cnt = 0;
    int ext_cnt = 0;
    int cyc = 0;

    pms_top u_dut (.clk(clk), .reset(reset), .mode_select_pin(mode_select_pin),
        .mode_wr(mode_wr), .mode_wdata(mode_wdata), .e_stop(e_stop), .phi1_en(phi1_en),
        .e_strobe(e_strobe), .phi1(phi1), .cpu_req(cpu_req), .cpu_rvalid(cpu_rvalid),
        .cpu_rdata(cpu_rdata), .int_req(int_req), .int_rdata(int_rdata), .ext_req(ext_req),
        .ext_rdata(ext_rdata), .bus_out(bus_out), .bus_oe(bus_oe), .bus_in(bus_in),
        .port_out(port_out), .port_dir(port_dir), .port_in(port_in), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .e_pin_out(e_pin_out), .e_pin_oe(e_pin_oe),
        .mode(mode));
    pms_ext_model u_ext (.clk(clk), .reset(reset), .ext_req(ext_req), .ext_rdata(ext_rdata));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // ================================================================
    // Internal memory stand-in, strobe counters and read scoreboard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            $display("CHECK FAILED at %0t: run did not finish in time", $time);
            stop_test();
        end
        if (int_req.valid === 1'b1) begin
            int_cnt++;
            int_wd = int_req.wdata;
            int_rdata <= int_req.addr[15:0] ^ 16'h5a5a;
        end else begin
            int_rdata <= ~int_rdata;
        end
        if (ext_req.valid === 1'b1) begin
            ext_cnt++;
            ext_wd = ext_req.wdata;
        end
        if (reset === 1'b0 && cpu_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(1'b0, "read answer nobody asked for");
            end else begin
                chk(cpu_rdata === exp_q.pop_front(), "read data");
            end
        end
    end

    // ================================================================
    // Shared tasks
    task automatic chk(input bit ok, input string msg);
        total_checks++;
        if (!ok) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic tick(input int n = 1);
        repeat (n) begin
            @(posedge clk);
            #2;
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic strap);
        reset = 1'b1;
        mode_select_pin = strap;
        tick(2);
        chk(mode === PMS_SINGLE, "mode during reset");
        reset = 1'b0;
        tick(2);
    endtask

    task automatic rnd_io();
        port_out = 40'({$urandom(), $urandom()});
        port_dir = 40'({$urandom(), $urandom()});
        bus_out = 34'({$urandom(), $urandom()});
        bus_oe = 34'({$urandom(), $urandom()});
        pin_in = 40'({$urandom(), $urandom()});
        phi1 = 1'($urandom());
        #1;
    endtask

    // One access, then the strobe counts and write data on each side
    task automatic access(input bit w, input logic [23:0] a, input int ni, input int ne);
        int i0, e0;
        logic [15:0] d;
        i0 = int_cnt;
        e0 = ext_cnt;
        d = 16'($urandom());
        cpu_req = '{valid: 1'b1, write: w, addr: a, wdata: d};
        tick();
        cpu_req.valid = 1'b0;
        if (!w && ni > 0) exp_q.push_back(a[15:0] ^ 16'h5a5a);
        else if (!w && ne > 0) exp_q.push_back(a[15:0] ^ 16'h3c3c);
        tick(4);
        chk(int_cnt - i0 == ni && ext_cnt - e0 == ne, "strobe counts");
        if (w && ni > 0) chk(int_wd === d, "internal write data");
        if (w && ne > 0) chk(ext_wd === d, "external write data");
    endtask

    task automatic set_mode(input logic [1:0] code, input pms_mode_e expm);
        pms_mode_e old;
        old = mode;
        mode_wr = 1'b1;
        mode_wdata = code;
        tick();
        mode_wr = 1'b0;
        tick();
        chk(mode === old, "mode changed before strobe edge");
        e_strobe = 1'b1;
        tick();
        e_strobe = 1'b0;
        chk(mode === expm, "mode after strobe edge");
    endtask

    task automatic chk_pins(input pms_mode_e m);
        if (m == PMS_SINGLE) begin
            chk(pin_out === port_out && pin_oe === port_dir, "single-chip pins");
        end else begin
            chk(pin_out[33:0] === bus_out && pin_oe[33:0] === bus_oe, "bus pins");
            chk(pin_out[39:35] === port_out[39:35], "upper port pins");
        end
        if (m == PMS_MICRO) begin
            chk(pin_oe[34] === 1'b1 && pin_out[34] === (phi1 & phi1_en), "clock pin");
        end
    endtask

    // ================================================================
    // Main sequence
    initial begin
        logic [23:0] ra;
        void'($urandom(56795));
        do_reset(1'b0);
        chk(mode === PMS_SINGLE, "mode after strap low");
        rnd_io();
        chk_pins(PMS_SINGLE);
        tick(2);
        chk(port_in === pin_in && bus_in === pin_in[33:0], "pad samples");
        e_stop = 1'b1;
        #1;
        chk(e_pin_oe === 1'b0, "strobe output stopped");
        e_stop = 1'b0;
        #1;
        chk(e_pin_oe === 1'b1 && e_pin_out === e_strobe, "strobe output");
        access(1'b0, 24'h000100, 1, 0);
        access(1'b0, 24'h008010, 1, 0);
        access(1'b0, 24'h123456, 0, 0);
        access(1'b1, PMS_RSV_A, 0, 0);
        access(1'b1, PMS_RSV_B, 0, 0);
        access(1'b1, PMS_RSV_C, 0, 0);
        access(1'b1, 24'h000063, 1, 0);
        set_mode(2'h3, PMS_SINGLE);
        set_mode(2'h1, PMS_EXPAND);
        chk_pins(PMS_EXPAND);
        e_stop = 1'b1;
        phi1_en = 1'b1;
        #1;
        chk(e_pin_oe === 1'b1, "strobe kept in external mode");
        chk(pin_out[34] === phi1, "clock pin in expansion");
        access(1'b0, 24'h000200, 1, 1);
        access(1'b0, 24'h009000, 1, 1);
        access(1'b1, 24'h000300, 1, 1);
        access(1'b1, PMS_RSV_A, 0, 1);
        repeat (4) access(1'b0, 24'h010000 + 24'($urandom_range(24'hfeffff)), 0, 1);
        for (int i = 0; i < 6; i++) begin
            ra = 24'h000080 + 24'($urandom_range(12'h7ff));
            cpu_req = '{valid: 1'b1, write: 1'b0, addr: ra, wdata: 16'h0000};
            exp_q.push_back(ra[15:0] ^ 16'h5a5a);
            tick();
        end
        cpu_req.valid = 1'b0;
        tick(4);
        rnd_io();
        set_mode(2'h2, PMS_MICRO);
        chk_pins(PMS_MICRO);
        phi1_en = 1'b0;
        #1;
        chk_pins(PMS_MICRO);
        access(1'b0, 24'h00a000, 0, 1);
        access(1'b0, 24'h000400, 1, 1);
        set_mode(2'h0, PMS_SINGLE);
        chk_pins(PMS_SINGLE);
        do_reset(1'b1);
        chk(mode === PMS_MICRO, "mode after strap high");
        // A strapped device may only be given the microprocessor code
        set_mode(2'h2, PMS_MICRO);
        set_mode(2'h2, PMS_MICRO);
        chk(exp_q.size() == 0, "reads left unanswered");
        stop_test();
    end
endmodule
